// ===== rtl/sds_params.svh
/*
  Constants of the sensor-data SPI command block: frame layout, command
  codes, health codes, CRC settings and buffer sizes.
  Assumes it is included by bare name from the package and the command decoder module; the FIFO does not use it.
*/
`ifndef SDS_PARAMS_SVH
`define SDS_PARAMS_SVH

// frame geometry
`define SDS_FRAME_BITS 32
`define SDS_IDX_BITS 5
`define SDS_CMD_MSB 31
`define SDS_CMD_LSB 28
`define SDS_BODY_BITS 24

// sample sources and the sample store
`define SDS_SRC_BITS 3
`define SDS_SRC_COUNT 8
`define SDS_SAMPLE_BITS 16
`define SDS_COARSE_SAMPLE_BITS 12
`define SDS_EXT_BITS 4
`define SDS_FIFO_DEPTH 8

// command codes in bits 31..28 that carry no function here
`define SDS_CMD_RSV_0 4'h0
`define SDS_CMD_RSV_2 4'h2
`define SDS_CMD_RSV_4 4'h4
`define SDS_CMD_RSV_6 4'h6
`define SDS_CMD_RSV_A 4'ha
`define SDS_CMD_RSV_E 4'he

// coarse health codes, fine code used for a frame error
`define SDS_COARSE_INIT 2'h0
`define SDS_COARSE_NORMAL 2'h1
`define SDS_COARSE_SELFTEST 2'h2
`define SDS_COARSE_ERROR 2'h3
`define SDS_FINE_NONE 2'h0
`define SDS_FINE_FRAME_ERR 2'h3

// crc: x^8+x^5+x^3+x^2+x+1, shifted in msb first
`define SDS_CRC_POLY 8'h2f
`define SDS_CRC_SEED 8'hff

`endif

// ===== rtl/sds_pkg.sv
/*
  Types of the sensor-data SPI command block.
  Assumes sds_params.svh is on the include path.
*/
`include "sds_params.svh"

package sds_pkg;

  // what the next response frame answers
  typedef enum logic [2:0] {
    SDS_KIND_NONE = 3'b000,
    SDS_KIND_SENSOR = 3'b001,
    SDS_KIND_RESERVED = 3'b010,
    SDS_KIND_FRAME_ERR = 3'b011,
    SDS_KIND_OTHER = 3'b100
  } sds_kind_type;

  // one sample delivered by the conversion logic
  typedef struct packed {
    logic [`SDS_SRC_BITS-1:0] source_select_code;
    logic [`SDS_SAMPLE_BITS-1:0] sample_value;
  } sds_sample_type;

  // the 24 bits of a response in front of its crc
  typedef struct packed {
    logic [3:0] cmd_echo;
    logic [1:0] coarse_health_code;
    logic [`SDS_COARSE_SAMPLE_BITS-1:0] sample_value;
    logic [`SDS_EXT_BITS-1:0] sample_ext;
    logic [1:0] fine_health_code;
  } sds_body_type;

endpackage

// ===== rtl/sds_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides and registered flags.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none

module sds_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic [AW:0] count_d;
  logic in_ready_q;
  logic out_valid_q;
  wire push = in_valid & in_ready_q;
  wire pop = out_valid_q & out_ready;

  // flags come from the next count so both sides see honest full/empty
  assign count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
  assign in_ready = in_ready_q;
  assign out_valid = out_valid_q;
  assign out_data = mem_q[rd_ptr_q];

  // storage is never reset; valid gating keeps stale words unseen
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      in_ready_q <= 1'b0;
      out_valid_q <= 1'b0;
    end else begin
      wr_ptr_q <= push ? AW'((wr_ptr_q + 1'b1) % DEPTH) : wr_ptr_q;
      rd_ptr_q <= pop ? AW'((rd_ptr_q + 1'b1) % DEPTH) : rd_ptr_q;
      count_q <= count_d;
      in_ready_q <= (count_d < (AW+1)'(DEPTH));
      out_valid_q <= (count_d != '0);
    end
  end

endmodule

`default_nettype wire

// ===== rtl/sds_spi_cmd.sv
/*
  Sensor-data and reserved-command part of a 32-bit SPI command decoder.
  Holds the link shifter on the SPI clock, the frame decoder and response
  builder on SYS_CLK, and a sample store fed through an 8-word FIFO.
  Assumes: SPI clock idles low, device launches on the rising edge and
  samples MOSI on the falling edge; the host keeps chip select low for at
  least 5 SYS_CLK cycles before the first SPI clock edge and high for at
  least 5 SYS_CLK cycles between frames. Register read/write answers and the
  complete error handling live in neighbouring blocks.
*/
`timescale 1ns/1ns
`default_nettype none

`include "sds_params.svh"

module sds_spi_cmd (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic SPI_SCLK,
  input wire logic SPI_CS_N,
  input wire logic SPI_MOSI,
  output logic SPI_MISO,
  output logic SPI_MISO_OE,
  input wire logic SAMPLE_VALID,
  output logic SAMPLE_READY,
  input wire sds_pkg::sds_sample_type SAMPLE_IN,
  input wire logic INIT_DONE_FLAG,
  input wire logic SELF_TEST_ACTIVE,
  input wire logic INTERNAL_ERROR,
  input wire logic [1:0] FINE_HEALTH_IN,
  input wire logic HIGH_RES_EN,
  output logic CMD_FWD_VALID,
  output logic [`SDS_FRAME_BITS-1:0] CMD_FWD_WORD,
  output logic CRC_ERR_PULSE,
  output sds_pkg::sds_kind_type PENDING_KIND
);

  // crc over a whole 32-bit word, msb first, rotated into the lsb
  function automatic logic [7:0] crc8_word(input logic [`SDS_FRAME_BITS-1:0] word);
    logic [7:0] crc;
    logic fb;
    crc = `SDS_CRC_SEED;
    for (int i = `SDS_FRAME_BITS - 1; i >= 0; i--) begin
      fb = crc[7];
      crc = {crc[6:0], word[i]} ^ (fb ? `SDS_CRC_POLY : 8'h00);
    end
    return crc;
  endfunction

  // true for the six command nibbles without a function
  function automatic logic is_reserved(input logic [3:0] cmd);
    return (cmd == `SDS_CMD_RSV_0) || (cmd == `SDS_CMD_RSV_2) ||
           (cmd == `SDS_CMD_RSV_4) || (cmd == `SDS_CMD_RSV_6) ||
           (cmd == `SDS_CMD_RSV_A) || (cmd == `SDS_CMD_RSV_E);
  endfunction

  // link domain, SPI clock
  logic [`SDS_IDX_BITS-1:0] tx_idx_q;
  logic miso_q;
  logic oe_q;
  logic [`SDS_FRAME_BITS-1:0] rx_shift_q;

  // system domain
  logic cs_s1_q;
  logic cs_s2_q;
  logic cs_s3_q;
  logic cs_level_q;
  logic [`SDS_FRAME_BITS-1:0] tx_word_q;
  logic [`SDS_FRAME_BITS-1:0] tx_word_d;
  sds_pkg::sds_kind_type kind_q;
  sds_pkg::sds_kind_type kind_d;
  logic [3:0] cmd_q;
  logic [1:0] coarse_q;
  logic [1:0] coarse_d;
  logic [1:0] fine_q;
  logic [1:0] fine_d;
  logic [`SDS_SAMPLE_BITS-1:0] table_q [`SDS_SRC_COUNT];
  logic fwd_valid_q;
  logic [`SDS_FRAME_BITS-1:0] fwd_word_q;
  logic crc_err_q;

  // buffer between the conversion logic and the sample store
  logic fifo_in_ready;
  logic fifo_out_valid;
  sds_pkg::sds_sample_type fifo_out;
  logic store_ready;

  // the store only takes new samples between frames, so the sample held
  // at chip select fall stays fixed; the fifo absorbs the stall meanwhile
  assign store_ready = cs_level_q;

  sds_fifo #(
    .WIDTH($bits(sds_pkg::sds_sample_type)),
    .DEPTH(`SDS_FIFO_DEPTH)
  ) u_fifo (
    .clk(SYS_CLK),
    .rst(RST),
    .in_valid(SAMPLE_VALID),
    .in_ready(fifo_in_ready),
    .in_data(SAMPLE_IN),
    .out_valid(fifo_out_valid),
    .out_ready(store_ready),
    .out_data(fifo_out)
  );

  // transmit side: launches one response bit per rising edge, msb first;
  // chip select high clears it because the clock stops between frames
  always_ff @(posedge SPI_SCLK or posedge SPI_CS_N) begin
    if (SPI_CS_N) begin
      tx_idx_q <= '0;
      miso_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      miso_q <= tx_word_q[5'd31 - tx_idx_q];
      tx_idx_q <= tx_idx_q + 1'b1;
      oe_q <= 1'b1;
    end
  end

  // receive side: shifts the command in on falling edges; after the last
  // edge it holds still, so the system side may read it as a static word
  always_ff @(negedge SPI_SCLK) begin
    rx_shift_q <= {rx_shift_q[`SDS_FRAME_BITS-2:0], SPI_MOSI};
  end

  assign SPI_MISO = miso_q;
  assign SPI_MISO_OE = oe_q;

  // chip select crosses on three flops; a change counts once two agree
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
    end else begin
      cs_s1_q <= SPI_CS_N;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
    end
  end

  // frame edges seen by the system side
  wire cs_agree = (cs_s2_q == cs_s3_q);
  wire cs_fall = cs_agree & cs_level_q & ~cs_s3_q;
  wire cs_rise = cs_agree & ~cs_level_q & cs_s3_q;

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      cs_level_q <= 1'b1;
    end else if (cs_agree) begin
      cs_level_q <= cs_s3_q;
    end
  end

  // decoding of the word that just ended; rx_shift_q is static here
  wire [3:0] rx_cmd = rx_shift_q[`SDS_CMD_MSB:`SDS_CMD_LSB];
  wire rx_crc_ok = (crc8_word(rx_shift_q) == 8'h00);
  wire rx_sensor = rx_cmd[0];
  wire rx_reserved = is_reserved(rx_cmd);

  // a bad crc overrides every command; neighbours answer the rest
  assign kind_d = !rx_crc_ok ? sds_pkg::SDS_KIND_FRAME_ERR :
                  rx_sensor ? sds_pkg::SDS_KIND_SENSOR :
                  rx_reserved ? sds_pkg::SDS_KIND_RESERVED :
                  sds_pkg::SDS_KIND_OTHER;

  // health priority: frame error, then internal error, then self-test, then init, then normal
  always_comb begin
    coarse_d = `SDS_COARSE_NORMAL;
    fine_d = `SDS_FINE_NONE;
    if (!rx_crc_ok) begin
      coarse_d = `SDS_COARSE_ERROR;
      fine_d = `SDS_FINE_FRAME_ERR;
    end else if (INTERNAL_ERROR) begin
      coarse_d = `SDS_COARSE_ERROR;
      fine_d = FINE_HEALTH_IN;
    end else if (SELF_TEST_ACTIVE) begin
      coarse_d = `SDS_COARSE_SELFTEST;
    end else if (!INIT_DONE_FLAG) begin
      coarse_d = `SDS_COARSE_INIT;
    end
  end

  // latch command and device state at the rise that ends the command
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      kind_q <= sds_pkg::SDS_KIND_NONE;
      cmd_q <= 4'h0;
      coarse_q <= `SDS_COARSE_INIT;
      fine_q <= `SDS_FINE_NONE;
    end else if (cs_rise) begin
      kind_q <= kind_d;
      cmd_q <= rx_cmd;
      coarse_q <= coarse_d;
      fine_q <= fine_d;
    end
  end

  // response body for the pending command, sample read at the fall
  sds_pkg::sds_body_type body;
  wire [`SDS_SAMPLE_BITS-1:0] picked = table_q[cmd_q[3:1]];

  always_comb begin
    body = '0;
    body.coarse_health_code = coarse_q;
    body.fine_health_code = fine_q;
    case (kind_q)
      sds_pkg::SDS_KIND_SENSOR: begin
        body.cmd_echo = cmd_q;
        body.sample_value = picked[`SDS_SAMPLE_BITS-1:`SDS_EXT_BITS];
        body.sample_ext = HIGH_RES_EN ? picked[`SDS_EXT_BITS-1:0] : 4'h0;
      end
      sds_pkg::SDS_KIND_RESERVED: begin
        body = '0;
      end
      sds_pkg::SDS_KIND_FRAME_ERR: begin
        body.cmd_echo = cmd_q;
      end
      sds_pkg::SDS_KIND_OTHER: begin
        body.cmd_echo = cmd_q;
      end
      sds_pkg::SDS_KIND_NONE: begin
        body.cmd_echo = 4'h0;
      end
      default: begin
        body = '0;
      end
    endcase
  end

  // crc over body plus eight zero bits, so the trailing byte is the crc
  wire [7:0] resp_crc = crc8_word({body, 8'h00});
  assign tx_word_d = {body, resp_crc};

  // the word is built at the fall and then stays put for the whole frame;
  // the transmit side reads it only after the host's lead time has passed
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      tx_word_q <= '0;
    end else if (cs_fall) begin
      tx_word_q <= tx_word_d;
    end
  end

  // sample store, refilled from the fifo only while chip select is high
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      for (int i = 0; i < `SDS_SRC_COUNT; i++) begin
        table_q[i] <= '0;
      end
    end else if (fifo_out_valid && store_ready) begin
      table_q[fifo_out.source_select_code] <= fifo_out.sample_value;
    end
  end

  // hand-off to the neighbouring register logic and error reporting
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      fwd_valid_q <= 1'b0;
      fwd_word_q <= '0;
      crc_err_q <= 1'b0;
    end else begin
      fwd_valid_q <= cs_rise && (kind_d == sds_pkg::SDS_KIND_OTHER);
      fwd_word_q <= cs_rise ? rx_shift_q : fwd_word_q;
      crc_err_q <= cs_rise && !rx_crc_ok;
    end
  end

  assign SAMPLE_READY = fifo_in_ready;
  assign CMD_FWD_VALID = fwd_valid_q;
  assign CMD_FWD_WORD = fwd_word_q;
  assign CRC_ERR_PULSE = crc_err_q;
  assign PENDING_KIND = kind_q;

endmodule

`default_nettype wire

// ===== test/sds_spi_cmd_sva.sv
/*
  checker of the sensor-data spi command block, bound to its top ports.
  assumes one system clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none
module sds_spi_cmd_sva (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic SPI_CS_N,
  input wire logic SPI_MISO,
  input wire logic SPI_MISO_OE,
  input wire logic SAMPLE_VALID,
  input wire logic SAMPLE_READY,
  input wire logic CMD_FWD_VALID,
  input wire logic [31:0] CMD_FWD_WORD,
  input wire logic CRC_ERR_PULSE,
  input wire sds_pkg::sds_kind_type PENDING_KIND
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // chip select high long enough for the synchroniser to have seen it
  sequence cs_seen;
    SPI_CS_N && $past(SPI_CS_N, 2);
  endsequence
  // the line is released between frames
  line_idle_a: assert property (SPI_CS_N |-> !SPI_MISO_OE && !SPI_MISO)
    else $error("miso driven outside a frame");
  fwd_kind_a: assert property (CMD_FWD_VALID |-> !CMD_FWD_WORD[28] ##0 cs_seen
    ##0 PENDING_KIND == sds_pkg::SDS_KIND_OTHER) else $error("bad forward");
  fwd_once_a: assert property (CMD_FWD_VALID |=> !CMD_FWD_VALID)
    else $error("forward pulse too long");
  err_kind_a: assert property (CRC_ERR_PULSE |-> cs_seen ##0 !CMD_FWD_VALID
    ##0 PENDING_KIND == sds_pkg::SDS_KIND_FRAME_ERR) else $error("bad crc flag");
  err_once_a: assert property (CRC_ERR_PULSE |=> !CRC_ERR_PULSE)
    else $error("crc pulse too long");
  // the decoder only moves once a frame has ended
  kind_move_a: assert property (!$stable(PENDING_KIND) |-> cs_seen)
    else $error("kind changed inside a frame");
  // the fifo can only fill while the drain is stalled by a frame
  ready_fill_a: assert property ($fell(SAMPLE_READY) |-> !$past(SPI_CS_N, 5))
    else $error("fifo full outside a frame");
  ready_back_a: assert property ((SPI_CS_N && !SAMPLE_VALID)[*8] |-> SAMPLE_READY)
    else $error("fifo not draining");
endmodule
`default_nettype wire

// ===== test/sds_spi_host.sv
/*
  spi host model: 32-bit frames, clock idles low and runs only in frames.
  assumes the device samples on the falling and launches on the rising edge.
*/
`timescale 1ns/1ns
`default_nettype none
module sds_spi_host (
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  // idle state of the link
  // chip select starts low and rises at 1 ns, so the design's link flops see a
  // real clearing edge instead of one lost in the race at time zero
  initial begin
    sclk = 1'b0;
    cs_n = 1'b0;
    mosi = 1'b1;
    #1 cs_n = 1'b1;
  end
  // one frame msb first; the odd setup keeps the rising link edges off the system edges
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    cs_n = 1'b0;
    #23;
    for (int i = 31; i >= 0; i--) begin
      sclk = 1'b1;
      mosi = tx[i];
      #3 rx[i] = miso;
      sclk = 1'b0;
      #3;
    end
    #4 cs_n = 1'b1;
    mosi = ~mosi; // released line shows no stale bit
    // 248 ns per frame keeps every frame start, and the checks after it, off the system rising edge
    #29;
  endtask
endmodule
`default_nettype wire

// ===== test/sds_spi_cmd_tb_top.sv
/*
  testbench of the sensor-data spi command block.
  assumes the design, its package, the host model and the checker are compiled.
*/
`timescale 1ns/1ns
`default_nettype none
module sds_spi_cmd_tb_top;
  logic SYS_CLK, RST, SPI_SCLK, SPI_CS_N, SPI_MOSI, SPI_MISO, SPI_MISO_OE, SAMPLE_VALID, SAMPLE_READY;
  logic INIT_DONE_FLAG, SELF_TEST_ACTIVE, INTERNAL_ERROR, HIGH_RES_EN, CMD_FWD_VALID, CRC_ERR_PULSE;
  logic [1:0] FINE_HEALTH_IN, p_st, p_fine;
  logic [31:0] CMD_FWD_WORD;
  logic [3:0] p_cmd;
  logic [3:0] rsv [6] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'ha, 4'he};
  logic [15:0] smp [8];
  sds_pkg::sds_sample_type SAMPLE_IN;
  sds_pkg::sds_kind_type PENDING_KIND, p_kind;
  int bad_count, checks;
  sds_spi_cmd uut (.SYS_CLK, .RST, .SPI_SCLK, .SPI_CS_N, .SPI_MOSI, .SPI_MISO, .SPI_MISO_OE,
    .SAMPLE_VALID, .SAMPLE_READY, .SAMPLE_IN, .INIT_DONE_FLAG, .SELF_TEST_ACTIVE, .INTERNAL_ERROR,
    .FINE_HEALTH_IN, .HIGH_RES_EN, .CMD_FWD_VALID, .CMD_FWD_WORD, .CRC_ERR_PULSE, .PENDING_KIND);
  sds_spi_host host (.sclk(SPI_SCLK), .cs_n(SPI_CS_N), .mosi(SPI_MOSI), .miso(SPI_MISO));
  // 250 MHz system clock
  initial begin
    SYS_CLK = 1'b0;
    forever #2 SYS_CLK = ~SYS_CLK;
  end
  // the run needs about 8 us, so a hang is cut off well after that
  initial begin
    #60000;
    bad_count++;
    wrap_up();
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // crc over the body then eight zeros, msb first
  function automatic logic [7:0] crc8(input logic [23:0] b);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 31; i >= 0; i--) begin
      c = {c[6:0], i > 7 ? b[i - 8] : 1'b0} ^ (c[7] ? 8'h2f : 8'h00);
    end
    return c;
  endfunction
  // one sample into the fifo; a one-cycle gap keeps valid changes apart
  task automatic push(input logic [2:0] s, input logic [15:0] v);
    @(negedge SYS_CLK);
    SAMPLE_IN = {s, v};
    SAMPLE_VALID = 1'b1;
    while (SAMPLE_READY !== 1'b1) @(negedge SYS_CLK);
    @(negedge SYS_CLK);
    SAMPLE_VALID = 1'b0;
    smp[s] = v;
  endtask
  // a frame checks the answer to the previous command and records this one
  task automatic frame(input logic [3:0] c, input logic bad);
    logic [23:0] e;
    logic [31:0] w, r;
    logic [15:0] v;
    v = smp[p_cmd[3:1]];
    e = 24'h000000;
    if (p_kind == sds_pkg::SDS_KIND_SENSOR) e = {p_cmd, p_st, v[15:4], HIGH_RES_EN ? v[3:0] : 4'h0, p_fine};
    if (p_kind == sds_pkg::SDS_KIND_FRAME_ERR) e = {p_cmd, 2'h3, 16'h0000, 2'h3};
    if (p_kind == sds_pkg::SDS_KIND_OTHER) e = {p_cmd, p_st, 16'h0000, p_fine};
    w = {c, 20'h00000, crc8({c, 20'h00000}) ^ {7'h00, bad}};
    host.xfer(w, r);
    check(r, {e, crc8(e)});
    p_cmd = c;
    p_st = INTERNAL_ERROR ? 2'h3 : SELF_TEST_ACTIVE ? 2'h2 : {1'b0, INIT_DONE_FLAG};
    p_fine = INTERNAL_ERROR ? FINE_HEALTH_IN : 2'h0;
    p_kind = bad ? sds_pkg::SDS_KIND_FRAME_ERR : c[0] ? sds_pkg::SDS_KIND_SENSOR
      : c[3] && c[1:0] == 2'h0 ? sds_pkg::SDS_KIND_OTHER : sds_pkg::SDS_KIND_RESERVED;
    check({29'h0, PENDING_KIND}, {29'h0, p_kind});
    if (p_kind == sds_pkg::SDS_KIND_OTHER) check(CMD_FWD_WORD, w);
  endtask
  // main sequence
  initial begin
    {RST, SAMPLE_VALID, INIT_DONE_FLAG, SELF_TEST_ACTIVE, INTERNAL_ERROR, HIGH_RES_EN} = 6'h20;
    {FINE_HEALTH_IN, p_cmd, p_st, p_fine} = 10'h000;
    SAMPLE_IN = '0;
    p_kind = sds_pkg::SDS_KIND_NONE;
    foreach (smp[i]) smp[i] = 16'h0000;
    repeat (3) @(negedge SYS_CLK);
    RST = 1'b0;
    @(negedge SYS_CLK);
    check({24'h0, SPI_MISO_OE, SPI_MISO, SAMPLE_READY, CMD_FWD_VALID, CRC_ERR_PULSE, PENDING_KIND}, 32'h20);
    for (int s = 0; s < 8; s++) push(3'(s), {4'(s + 9), 12'h3c5});
    repeat (8) @(negedge SYS_CLK);
    frame(4'h1, 1'b0);
    for (int h = 0; h < 2; h++) begin
      HIGH_RES_EN = h[0];
      for (int s = 0; s < 8; s++) begin
        INIT_DONE_FLAG = s != 0;
        SELF_TEST_ACTIVE = s % 4 == 2;
        INTERNAL_ERROR = s % 4 == 3;
        FINE_HEALTH_IN = 2'(s + h);
        frame({3'(s), 1'b1}, 1'b0);
        push(3'(s), {4'(s), 12'(h * 273 + s)});
        repeat (8) @(negedge SYS_CLK);
      end
    end
    foreach (rsv[i]) frame(rsv[i], 1'b0);
    frame(4'h8, 1'b0);
    frame(4'h5, 1'b1);
    INTERNAL_ERROR = 1'b0;
    // the fifo fills while a frame stalls its drain
    fork
      frame(4'hb, 1'b0);
      begin
        repeat (10) @(negedge SYS_CLK);
        for (int s = 0; s < 8; s++) push(3'(s), 16'(20001 * s));
        check({31'h0, SAMPLE_READY}, 32'h0);
      end
    join
    repeat (12) @(negedge SYS_CLK);
    frame(4'h1, 1'b0);
    frame(4'h1, 1'b0);
    wrap_up();
  end
endmodule
bind sds_spi_cmd sds_spi_cmd_sva chk (.SYS_CLK, .RST, .SPI_CS_N, .SPI_MISO, .SPI_MISO_OE, .SAMPLE_VALID,
  .SAMPLE_READY, .CMD_FWD_VALID, .CMD_FWD_WORD, .CRC_ERR_PULSE, .PENDING_KIND);
`default_nettype wire
